/* hdl/pmc_capture.sv */
// Microphone clock generation, dual-edge capture of two data pins and channel routing.
`timescale 1ns/1ps
module pmc_capture (
    input  wire logic                                       CLK_SYS,       // 20 MHz system clock.
    input  wire logic                                       RST,           // Synchronous reset, active high.
    input  wire logic                                       TDM_PRESENT,   // Primary port supplies a rate.
    input  wire logic                                       TDM_RATE_48K,  // Primary port at 48 kHz, else 16 kHz.
    input  wire logic                                       CLASSIFY_MODE, // Sound classification mode.
    input  wire logic [pmc_pkg::NUM_MICS-1:0]               MIC_ENABLE,    // Per-microphone enable.
    input  wire logic [pmc_pkg::NUM_MICS-1:0]               MIC_EDGE_FALL, // Capture edge, 1 selects falling.
    input  wire logic [1:0]                                 VOICE_COUNT,   // Voice inputs in use, 0 to 3.
    input  wire logic [pmc_pkg::NUM_VOICE-1:0][1:0]         VOICE_SEL,     // Microphone for each voice input.
    input  wire logic                                       MIC_DATA_IN_A, // Data pin for microphones 0 and 1.
    input  wire logic                                       MIC_DATA_IN_B, // Data pin for microphones 2 and 3.
    output logic                                            MIC_CLOCK_OUT, // Microphone clock output.
    output logic                                            RATE_HI,       // Clock currently at 3.072 MHz.
    output logic [pmc_pkg::NUM_VOICE-1:0][pmc_pkg::SAMPLE_W-1:0] VOICE_DATA, // 16 kHz voice words.
    output logic [pmc_pkg::NUM_VOICE-1:0]                   VOICE_ACTIVE,  // Voice inputs carrying audio.
    output logic                                            VOICE_VALID,   // One-cycle pulse, new voice words.
    output logic [pmc_pkg::NUM_MICS-1:0][pmc_pkg::SAMPLE_W-1:0] ROUTE_DATA, // Words for the serial bus.
    output logic [pmc_pkg::NUM_MICS-1:0]                    ROUTE_MASK,    // Channels free for the serial bus.
    output logic                                            ROUTE_VALID    // One-cycle pulse, new route words.
);

    pmc_pkg::pmc_state_t st_reg;
    pmc_pkg::pmc_state_t st_next;

    logic [pmc_pkg::NUM_MICS-1:0][pmc_pkg::SAMPLE_W-1:0] mic_word;
    logic [pmc_pkg::NUM_MICS-1:0]                        mic_stb;

    function automatic logic [pmc_pkg::NUM_MICS-1:0] pmc_onehot(input logic [1:0] sel);
        pmc_onehot = '0;
        pmc_onehot[sel] = 1'b1;
    endfunction : pmc_onehot

    // A level is taken only once the last two synchroniser stages agree, so a sample caught
    // mid-transition never reaches a filter.
    function automatic logic pmc_agree(input logic [pmc_pkg::SYNC_STAGES-1:0] sync, input logic held);
        pmc_agree = (sync[1] == sync[2]) ? sync[2] : held;
    endfunction : pmc_agree

    // The multiplier sits a hair above one third, so a full-scale negative sum lands one step
    // below the word range and must be clamped rather than wrapped.
    function automatic logic [pmc_pkg::SAMPLE_W-1:0] pmc_sat_word(input logic signed [17:0] q);
        if (q > 18'sh07fff) begin
            pmc_sat_word = 16'h7fff;
        end else if (q < -18'sh08000) begin
            pmc_sat_word = 16'h8000;
        end else begin
            pmc_sat_word = q[15:0];
        end
    endfunction : pmc_sat_word

    genvar g;
    generate
        for (g = 0; g < pmc_pkg::NUM_MICS; g++) begin : g_mic
            pmc_stream_if strm ();
            assign strm.in_stb  = st_reg.bit_stb[g];
            assign strm.in_bit  = st_reg.bit_val[g];
            assign mic_word[g]  = strm.out_word;
            assign mic_stb[g]   = strm.out_stb;
            pmc_cic u_cic (
                .clk  (CLK_SYS),
                .rst  (RST),
                .strm (strm)
            );
        end
    endgenerate

    always_comb begin
        pmc_pkg::pmc_rate_t            rate;
        logic [pmc_pkg::NCO_W:0]       sum;
        logic                          rise;
        logic                          fall;
        logic                          pin;
        logic [pmc_pkg::NUM_MICS-1:0]  used;
        logic [pmc_pkg::NUM_MICS-1:0][pmc_pkg::SAMPLE_W-1:0] word;
        logic [33:0]                   prod;
        logic                          rise_late;
        logic                          fall_late;
        rate = pmc_pkg::PMC_RATE_1M024;
        sum = '0;
        rise = 1'b0;
        fall = 1'b0;
        pin = 1'b0;
        used = '0;
        word = '0;
        prod = '0;
        rise_late = 1'b0;
        fall_late = 1'b0;
        st_next = st_reg;
        st_next.voice_stb = 1'b0;
        st_next.route_stb = 1'b0;

        if (CLASSIFY_MODE) begin
            rate = pmc_pkg::PMC_RATE_1M024;
        end else if (!TDM_PRESENT) begin
            rate = pmc_pkg::PMC_RATE_3M072;
        end else if (TDM_RATE_48K) begin
            rate = pmc_pkg::PMC_RATE_3M072;
        end else begin
            rate = pmc_pkg::PMC_RATE_1M024;
        end
        st_next.rate_hi = (rate == pmc_pkg::PMC_RATE_3M072);

        // A fractional divider keeps the average rate exact; each half period jitters by one cycle.
        sum = {1'b0, st_reg.acc} + {1'b0, st_reg.rate_hi ? pmc_pkg::NCO_STEP_HI : pmc_pkg::NCO_STEP_LO};
        st_next.acc = sum[pmc_pkg::NCO_W-1:0];
        if (sum[pmc_pkg::NCO_W]) begin
            st_next.mclk = ~st_reg.mclk;
        end
        rise = sum[pmc_pkg::NCO_W] & ~st_reg.mclk;
        fall = sum[pmc_pkg::NCO_W] & st_reg.mclk;
        // The pin path is four cycles deep, longer than a fast half period, so each edge is acted
        // on three cycles late; the filtered pin then still shows the half that ended on that edge.
        st_next.rise_dly = {st_reg.rise_dly[pmc_pkg::CAPTURE_DELAY-2:0], rise};
        st_next.fall_dly = {st_reg.fall_dly[pmc_pkg::CAPTURE_DELAY-2:0], fall};
        rise_late = st_reg.rise_dly[pmc_pkg::CAPTURE_DELAY-1];
        fall_late = st_reg.fall_dly[pmc_pkg::CAPTURE_DELAY-1];

        st_next.sync_a = {st_reg.sync_a[1:0], MIC_DATA_IN_A};
        st_next.sync_b = {st_reg.sync_b[1:0], MIC_DATA_IN_B};
        st_next.filt_a = pmc_agree(st_reg.sync_a, st_reg.filt_a);
        st_next.filt_b = pmc_agree(st_reg.sync_b, st_reg.filt_b);

        // Disabled microphones still clock zeros into their filters, so all filters keep the
        // frame timing and the output strobes never depend on which microphones are enabled.
        for (int m = 0; m < pmc_pkg::NUM_MICS; m++) begin
            pin = (m < 2) ? st_reg.filt_a : st_reg.filt_b;
            st_next.bit_stb[m] = MIC_EDGE_FALL[m] ? fall_late : rise_late;
            st_next.bit_val[m] = MIC_ENABLE[m] & pin;
            word[m] = MIC_ENABLE[m] ? mic_word[m] : '0;
        end

        for (int v = 0; v < pmc_pkg::NUM_VOICE; v++) begin
            if (CLASSIFY_MODE) begin
                st_next.voice_act[v] = (v == 0);
            end else begin
                st_next.voice_act[v] = (v < int'(VOICE_COUNT));
            end
            if (st_next.voice_act[v]) begin
                used = used | pmc_onehot(VOICE_SEL[v]);
            end
        end
        st_next.route_mask = MIC_ENABLE & ~used;

        if (mic_stb[0]) begin
            // Routed words leave at the filter rate: 48 kHz at the fast clock, else 16 kHz.
            st_next.route_data = word;
            st_next.route_stb = 1'b1;
            if (!st_reg.rate_hi) begin
                st_next.ph3 = 2'h0;
                for (int v = 0; v < pmc_pkg::NUM_VOICE; v++) begin
                    st_next.voice_data[v] = st_reg.voice_act[v] ? word[VOICE_SEL[v]] : '0;
                end
                st_next.voice_stb = 1'b1;
            end else begin
                // Averaging three words is a cheap extra low-pass ahead of the 3:1 drop.
                for (int m = 0; m < pmc_pkg::NUM_MICS; m++) begin
                    if (st_reg.ph3 == 2'h0) begin
                        st_next.sum3[m] = pmc_pkg::SUM3_W'($signed(word[m]));
                    end else begin
                        st_next.sum3[m] = st_reg.sum3[m] + pmc_pkg::SUM3_W'($signed(word[m]));
                    end
                end
                if (st_reg.ph3 == 2'(pmc_pkg::HI_DECIM3 - 1)) begin
                    st_next.ph3 = 2'h0;
                    for (int v = 0; v < pmc_pkg::NUM_VOICE; v++) begin
                        prod = 34'($signed(st_next.sum3[VOICE_SEL[v]]) * $signed({1'b0, pmc_pkg::DIV3_MULT}));
                        st_next.voice_data[v] = st_reg.voice_act[v] ? pmc_sat_word(prod[33:16]) : '0;
                    end
                    st_next.voice_stb = 1'b1;
                end else begin
                    st_next.ph3 = st_reg.ph3 + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_reg <= '0;
            st_reg.acc <= pmc_pkg::NCO_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign MIC_CLOCK_OUT = st_reg.mclk;
    assign RATE_HI       = st_reg.rate_hi;
    assign VOICE_DATA    = st_reg.voice_data;
    assign VOICE_ACTIVE  = st_reg.voice_act;
    assign VOICE_VALID   = st_reg.voice_stb;
    assign ROUTE_DATA    = st_reg.route_data;
    assign ROUTE_MASK    = st_reg.route_mask;
    assign ROUTE_VALID   = st_reg.route_stb;

endmodule : pmc_capture

/* hdl/pmc_pkg.sv */
// Shared constants and types for the pulse-density microphone capture block.
package pmc_pkg;

    localparam int SYS_CLK_HZ     = 20_000_000;
    localparam int MIC_RATE_LO_HZ = 1_024_000;
    localparam int MIC_RATE_HI_HZ = 3_072_000;
    localparam int NCO_W          = 24;
    localparam int NUM_MICS       = 4;
    localparam int NUM_VOICE      = 3;
    localparam int SYNC_STAGES    = 3;
    localparam int SAMPLE_W       = 16;
    localparam int CIC_DECIM_LOG2 = 6;
    localparam int CIC_W          = 19;
    localparam int HI_DECIM3      = 3;
    localparam int SUM3_W         = 18;
    localparam int CAPTURE_DELAY  = 3;

    // The divider toggles the microphone clock on each accumulator carry, so the
    // step is scaled for twice the microphone clock rate.
    localparam logic [NCO_W-1:0] NCO_STEP_LO =
        NCO_W'((64'(2 * MIC_RATE_LO_HZ) << NCO_W) / 64'(SYS_CLK_HZ));
    localparam logic [NCO_W-1:0] NCO_STEP_HI =
        NCO_W'((64'(2 * MIC_RATE_HI_HZ) << NCO_W) / 64'(SYS_CLK_HZ));
    localparam logic [NCO_W-1:0] NCO_RESET = 24'h000000;
    localparam logic [15:0] DIV3_MULT = 16'h5556;

    typedef enum logic {
        PMC_RATE_1M024 = 1'b0,
        PMC_RATE_3M072 = 1'b1
    } pmc_rate_t;

    typedef struct packed {
        logic [NCO_W-1:0]                        acc;
        logic                                    mclk;
        logic [SYNC_STAGES-1:0]                  sync_a;
        logic [SYNC_STAGES-1:0]                  sync_b;
        logic                                    filt_a;
        logic                                    filt_b;
        logic [NUM_MICS-1:0]                     bit_stb;
        logic [NUM_MICS-1:0]                     bit_val;
        logic [NUM_MICS-1:0][SUM3_W-1:0]         sum3;
        logic [1:0]                              ph3;
        logic [NUM_VOICE-1:0][SAMPLE_W-1:0]      voice_data;
        logic [NUM_VOICE-1:0]                    voice_act;
        logic                                    voice_stb;
        logic [NUM_MICS-1:0][SAMPLE_W-1:0]       route_data;
        logic [NUM_MICS-1:0]                     route_mask;
        logic                                    route_stb;
        logic                                    rate_hi;
        logic [CAPTURE_DELAY-1:0]                rise_dly;
        logic [CAPTURE_DELAY-1:0]                fall_dly;
    } pmc_state_t;

endpackage : pmc_pkg

/* hdl/pmc_stream_if.sv */
// Bit stream in, decimated words out, between the capture core and one filter.
`timescale 1ns/1ps
interface pmc_stream_if;
    logic                           in_stb;
    logic                           in_bit;
    logic                           out_stb;
    logic [pmc_pkg::SAMPLE_W-1:0]   out_word;

    modport src (output in_stb, output in_bit, input out_stb, input out_word);
    modport cic (input in_stb, input in_bit, output out_stb, output out_word);
endinterface : pmc_stream_if

/* hdl/pmc_cic.sv */
// Third-order decimating low-pass filter turning one microphone bit stream into words.
`timescale 1ns/1ps
module pmc_cic #(
    parameter int DECIM_LOG2 = pmc_pkg::CIC_DECIM_LOG2,
    parameter int W          = pmc_pkg::CIC_W
) (
    input  wire logic  clk,   // System clock.
    input  wire logic  rst,   // Synchronous reset, active high.
    pmc_stream_if.cic  strm   // Bit stream in, words out.
);

    typedef struct packed {
        logic [2:0][W-1:0]       integ;
        logic [2:0][W-1:0]       dly;
        logic [DECIM_LOG2-1:0]   cnt;
        logic                    stb;
        logic [pmc_pkg::SAMPLE_W-1:0] word;
    } pmc_cic_st_t;

    localparam logic [W-1:0] MID = W'(1) << (W - 2);
    localparam logic signed [W-1:0] POS_MAX = W'(32767);
    localparam logic signed [W-1:0] NEG_MAX = -W'(32768);

    pmc_cic_st_t st_reg;
    pmc_cic_st_t st_next;

    always_comb begin
        logic [W-1:0]        c1;
        logic [W-1:0]        c2;
        logic [W-1:0]        c3;
        logic signed [W-1:0] scaled;
        c1 = '0;
        c2 = '0;
        c3 = '0;
        scaled = '0;
        st_next = st_reg;
        st_next.stb = 1'b0;
        if (strm.in_stb) begin
            st_next.integ[0] = st_reg.integ[0] + W'(strm.in_bit);
            st_next.integ[1] = st_reg.integ[1] + st_reg.integ[0];
            st_next.integ[2] = st_reg.integ[2] + st_reg.integ[1];
            st_next.cnt = st_reg.cnt + 1'b1;
            if (&st_reg.cnt) begin
                c1 = st_reg.integ[2] - st_reg.dly[0];
                c2 = c1 - st_reg.dly[1];
                c3 = c2 - st_reg.dly[2];
                st_next.dly[0] = st_reg.integ[2];
                st_next.dly[1] = c1;
                st_next.dly[2] = c2;
                // Full scale overshoots the positive end by one step, so the word saturates at its ends.
                scaled = $signed(c3 - MID) >>> 2;
                if (scaled > POS_MAX) begin
                    st_next.word = 16'h7fff;
                end else if (scaled < NEG_MAX) begin
                    st_next.word = 16'h8000;
                end else begin
                    st_next.word = scaled[pmc_pkg::SAMPLE_W-1:0];
                end
                st_next.stb = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign strm.out_stb  = st_reg.stb;
    assign strm.out_word = st_reg.word;

endmodule : pmc_cic

/* dv/pmc_capture_monitor.sv */
// Concurrent checks on the capture block's ports.
`timescale 1ns/1ps
module pmc_capture_monitor (
    input wire logic                                             CLK_SYS,       // Clock.
    input wire logic                                             RST,           // Reset.
    input wire logic                                             TDM_PRESENT,   // Port present.
    input wire logic                                             TDM_RATE_48K,  // Port rate.
    input wire logic                                             CLASSIFY_MODE, // Classify mode.
    input wire logic [pmc_pkg::NUM_MICS-1:0]                     MIC_ENABLE,    // Enables.
    input wire logic [pmc_pkg::NUM_MICS-1:0]                     MIC_EDGE_FALL, // Capture edges.
    input wire logic [1:0]                                       VOICE_COUNT,   // Voice count.
    input wire logic                                             MIC_CLOCK_OUT, // Mic clock.
    input wire logic                                             RATE_HI,       // Fast rate.
    input wire logic [pmc_pkg::NUM_VOICE-1:0]                    VOICE_ACTIVE,  // Active voices.
    input wire logic                                             VOICE_VALID,   // Voice strobe.
    input wire logic [pmc_pkg::NUM_MICS-1:0][pmc_pkg::SAMPLE_W-1:0] ROUTE_DATA, // Route words.
    input wire logic                                             ROUTE_VALID    // Route strobe.
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic [7:0]  half_reg;
    logic [11:0] hold_reg;
    logic        clk_d_reg;
    logic        rate_d_reg;
    logic [3:0]  edge_d_reg;
    logic [11:0] gap_reg;
    // Half periods are only judged once the rate has been steady, since a switch leaves one odd half.
    // A new capture edge shifts the frame by half a clock, so it restarts the same steady count.
    always_ff @(posedge CLK_SYS) begin
        clk_d_reg <= MIC_CLOCK_OUT;
        rate_d_reg <= RATE_HI;
        edge_d_reg <= MIC_EDGE_FALL;
        if (RST || MIC_CLOCK_OUT != clk_d_reg) half_reg <= 8'h01;
        else if (half_reg != 8'hff) half_reg <= half_reg + 8'h01;
        if (RST || RATE_HI != rate_d_reg || MIC_EDGE_FALL != edge_d_reg) hold_reg <= 12'h000;
        else if (hold_reg != 12'hfff) hold_reg <= hold_reg + 12'h001;
        if (RST) gap_reg <= 12'hfff;
        else if (VOICE_VALID) gap_reg <= 12'h001;
        else if (gap_reg != 12'hfff) gap_reg <= gap_reg + 12'h001;
    end
    sequence s_classify; CLASSIFY_MODE [*3]; endsequence
    sequence s_tdm48; (TDM_PRESENT && TDM_RATE_48K && !CLASSIFY_MODE) [*3]; endsequence
    sequence s_tdm16; (TDM_PRESENT && !TDM_RATE_48K && !CLASSIFY_MODE) [*3]; endsequence
    sequence s_xtal; (!TDM_PRESENT && !CLASSIFY_MODE) [*3]; endsequence
    a_rate_classify: assert property (s_classify |-> !RATE_HI)
        else $error("fast clock in classify mode");
    a_rate_tdm48: assert property (s_tdm48 |-> RATE_HI)
        else $error("slow clock at 48 kHz");
    a_rate_tdm16: assert property (s_tdm16 |-> !RATE_HI)
        else $error("fast clock at 16 kHz");
    a_rate_crystal: assert property (s_xtal |-> RATE_HI)
        else $error("slow clock without port");
    a_half_slow: assert property ($changed(MIC_CLOCK_OUT) && hold_reg > 12'd40 && !RATE_HI
        |-> half_reg inside {8'd9, 8'd10})
        else $error("slow half period wrong");
    a_half_fast: assert property ($changed(MIC_CLOCK_OUT) && hold_reg > 12'd40 && RATE_HI
        |-> half_reg inside {8'd3, 8'd4})
        else $error("fast half period wrong");
    a_voice_spacing: assert property (VOICE_VALID && hold_reg == 12'hfff && gap_reg != 12'hfff
        |-> gap_reg inside {[12'd1245:12'd1255]})
        else $error("voice words not at 16 kHz");
    a_voice_late: assert property (hold_reg == 12'hfff && gap_reg != 12'hfff |-> gap_reg <= 12'd1255)
        else $error("voice words stopped");
    a_route_pulse: assert property (ROUTE_VALID |=> !ROUTE_VALID)
        else $error("route strobe too long");
    a_voice_count: assert property ((!CLASSIFY_MODE && VOICE_COUNT == 2'h2) [*3] |-> VOICE_ACTIVE == 3'h3)
        else $error("active voices differ from count");
    a_classify_one: assert property (s_classify |-> VOICE_ACTIVE[2:1] == 2'h0)
        else $error("classify uses more than one voice");
    a_disabled_zero: assert property ((!MIC_ENABLE[3]) [*3] ##0 ROUTE_VALID |-> ROUTE_DATA[3] == 16'h0000)
        else $error("disabled microphone word not zero");
endmodule : pmc_capture_monitor

bind pmc_capture pmc_capture_monitor u_monitor (.CLK_SYS, .RST, .TDM_PRESENT, .TDM_RATE_48K, .CLASSIFY_MODE,
    .MIC_ENABLE, .MIC_EDGE_FALL, .VOICE_COUNT, .MIC_CLOCK_OUT, .RATE_HI, .VOICE_ACTIVE, .VOICE_VALID,
    .ROUTE_DATA, .ROUTE_VALID);

/* dv/pmc_mic_model.sv */
// Four pulse-density microphones sharing two data pins.
`timescale 1ns/1ps
module pmc_mic_model (
    input wire logic       mclk,       // Microphone clock.
    input wire logic [3:0] level,      // Constant density of each microphone.
    input wire logic [3:0] wired_fall, // Edge each microphone is strapped to.
    output logic           pin_a,      // Data of microphones 0 and 1.
    output logic           pin_b       // Data of microphones 2 and 3.
);
    // A microphone drives only in the half period ending on its edge, so the other half shows its partner.
    assign pin_a = (wired_fall[0] == mclk) ? level[0] : level[1];
    assign pin_b = (wired_fall[2] == mclk) ? level[2] : level[3];
endmodule : pmc_mic_model

/* dv/tb.sv */
// Self-checking bench for the microphone capture block.
`timescale 1ns/1ps
module tb;
    logic            clk_sys = 1'b0;
    logic            rst = 1'b1;
    logic            tdm_present = 1'b1;
    logic            tdm_rate_48k = 1'b0;
    logic            classify_mode = 1'b0;
    logic [3:0]      mic_enable = 4'hf;
    logic [3:0]      mic_edge_fall = 4'ha;
    logic [3:0]      level = 4'h9;
    logic [1:0]      voice_count = 2'h0;
    logic [2:0][1:0] voice_sel = 6'h00;
    logic            pin_a, pin_b, mclk, rate_hi, voice_valid, route_valid;
    logic [2:0][15:0] voice_data;
    logic [2:0]      voice_active;
    logic [3:0][15:0] route_data;
    logic [3:0]      route_mask;
    int              err_count = 0;
    int              checks_done = 0;

    pmc_capture uut (.CLK_SYS(clk_sys), .RST(rst), .TDM_PRESENT(tdm_present), .TDM_RATE_48K(tdm_rate_48k),
        .CLASSIFY_MODE(classify_mode), .MIC_ENABLE(mic_enable), .MIC_EDGE_FALL(mic_edge_fall),
        .VOICE_COUNT(voice_count), .VOICE_SEL(voice_sel), .MIC_DATA_IN_A(pin_a), .MIC_DATA_IN_B(pin_b),
        .MIC_CLOCK_OUT(mclk), .RATE_HI(rate_hi), .VOICE_DATA(voice_data), .VOICE_ACTIVE(voice_active),
        .VOICE_VALID(voice_valid), .ROUTE_DATA(route_data), .ROUTE_MASK(route_mask), .ROUTE_VALID(route_valid));
    pmc_mic_model u_mics (.mclk(mclk), .level(level), .wired_fall(4'ha), .pin_a(pin_a), .pin_b(pin_b));

    always #25 clk_sys = ~clk_sys;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : tick

    // Three words flush the old contents of the third-order filters, five leave margin.
    task automatic wait_words(input int n);
        int k;
        k = 0;
        while (n > 0 && k < 9000) begin
            tick(1);
            k++;
            if (route_valid === 1'b1) n--;
        end
        check(16'(n), 16'h0000);
    endtask : wait_words

    task automatic test_rate(input logic pres, input logic r48, input logic cls, input logic hi);
        int cnt;
        logic last;
        logic [15:0] lo;
        tdm_present = pres;
        tdm_rate_48k = r48;
        classify_mode = cls;
        lo = hi ? 16'd307 : 16'd102;
        tick(60);
        check(16'(rate_hi), 16'(hi));
        cnt = 0;
        last = mclk;
        repeat (1000) begin
            tick(1);
            if (mclk !== last) cnt++;
            last = mclk;
        end
        check((16'(cnt) == lo + 16'h0001) ? lo : 16'(cnt), lo);
    endtask : test_rate

    task automatic test_capture(input logic [3:0] edges, input logic [3:0] en);
        int m;
        logic [15:0] exp;
        mic_edge_fall = edges;
        mic_enable = en;
        wait_words(5);
        for (m = 0; m < 4; m++) begin
            exp = level[(edges == 4'ha) ? m : m ^ 1] ? 16'h7fff : 16'h8000;
            check(route_data[m], en[m] ? exp : 16'h0000);
        end
        check(16'(route_mask), 16'(en));
    endtask : test_capture

    task automatic test_voice(input logic [1:0] cnt, input logic cls, input logic [2:0] act, input logic [3:0] mask);
        int v;
        mic_enable = 4'hf;
        voice_count = cnt;
        classify_mode = cls;
        voice_sel = {2'h0, 2'h1, 2'h3};
        wait_words(5);
        check(16'(voice_active), 16'(act));
        check(16'(route_mask), 16'(mask));
        for (v = 0; v < 3; v++) begin
            check(voice_data[v], act[v] ? (level[voice_sel[v]] ? 16'h7fff : 16'h8000) : 16'h0000);
        end
    endtask : test_voice

    initial begin
        tick(12);
        rst = 1'b0;
        test_rate(1'b1, 1'b1, 1'b0, 1'b1);
        test_rate(1'b0, 1'b0, 1'b0, 1'b1);
        test_rate(1'b1, 1'b1, 1'b1, 1'b0);
        test_rate(1'b1, 1'b0, 1'b0, 1'b0);
        test_capture(4'ha, 4'hf);
        test_capture(4'h5, 4'hf);
        test_capture(4'ha, 4'h7);
        test_capture(4'ha, 4'he);
        test_voice(2'h2, 1'b0, 3'h3, 4'h5);
        test_voice(2'h3, 1'b0, 3'h7, 4'h4);
        test_voice(2'h3, 1'b1, 3'h1, 4'h7);
        tdm_rate_48k = 1'b1;
        test_voice(2'h3, 1'b0, 3'h7, 4'h4);
        test_done();
    end

    initial begin
        #5_000_000;
        err_count++;
        test_done();
    end
endmodule : tb
